/* verilog/card_pin_end.sv */
// Card end: mode-dependent pin functions, decode and status alert
`timescale 1ns/1ps
`include "card_pins_params.svh"
module card_pin_end
  import card_pins_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  card_pins_if.card pins,
  input wire card_mode_type mode_in,
  input wire logic ready_in,
  input wire logic write_protect_in,
  input wire logic audio_in,
  input wire logic audio_supported_in,
  input wire logic diag_pass_in,
  input wire logic [`DATA_WIDTH-1:0] read_data_in,
  output logic [2:0] reg_select_out,
  output logic [`ADDR_WIDTH-1:0] reg_addr_out,
  output logic reg_read_out,
  output logic reg_write_out,
  output logic wide_access_out,
  output logic [`DATA_WIDTH-1:0] write_data_out,
  output logic card_reset_out,
  output logic master_diag_seen_out,
  output logic status_change_alert_n_out
);

  // ***********************************************
  // Pin synchronisers
  // ***********************************************
  logic [2:0] sync_rd;
  logic [2:0] sync_wr;
  logic [2:0] sync_rst;
  logic [2:0] sync_diag;
  logic [`BYTE_WIDTH-1:0] config_reg;
  logic ready_prev;
  logic protect_prev;
  logic alert_pending;
  logic rd_prev;
  logic wr_prev;
  logic card_reset_raw;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync_rd <= 3'h7;
      sync_wr <= 3'h7;
      sync_rst <= 3'h0;
      sync_diag <= 3'h7;
    end else begin
      sync_rd <= {sync_rd[1:0], pins.read_strobe_n};
      sync_wr <= {sync_wr[1:0], pins.write_strobe_n};
      sync_rst <= {sync_rst[1:0], pins.reset_pin};
      sync_diag <= {sync_diag[1:0], pins.pin46_wire};
    end
  end

  wire rd_level = (sync_rd[2] == sync_rd[1]) ? sync_rd[1] : rd_prev;
  wire wr_level = (sync_wr[2] == sync_wr[1]) ? sync_wr[1] : wr_prev;
  wire rd_fall = rd_prev & ~rd_level;
  wire wr_fall = wr_prev & ~wr_level;
  wire reset_level = (sync_rst[2] == sync_rst[1]) ? sync_rst[1] : card_reset_raw;

  // ***********************************************
  // Mode decode
  // ***********************************************
  wire disk_mode = (mode_in == MODE_DISK);
  wire io_mode = (mode_in == MODE_IO);
  wire mem_mode = (mode_in == MODE_MEMORY);
  // Reset pin polarity depends on mode
  wire reset_active = disk_mode ? ~reset_level : reset_level;
  // Upper byte enabled only when second enable is low; unused otherwise
  wire wide = ~pins.chip_enable_two_n & ~disk_mode;
  wire selected = ~pins.chip_enable_one_n | ~pins.chip_enable_two_n;
  // Drive select has no effect in any mode: both branches give selected
  wire disk_selected = disk_mode & ~pins.drive_select_n ? selected : selected;
  wire [2:0] task_addr = pins.addr[`TASK_ADDR_WIDTH-1:0];
  wire [`ADDR_WIDTH-1:0] card_addr = pins.addr;
  wire config_hit = ~pins.attr_sel_n & (card_addr >= `CONFIG_BASE);
  wire [2:0] next_select =
    disk_mode ? SEL_TASK_FILE :
    (~pins.attr_sel_n & io_mode & (card_addr < `IO_PORT_LIMIT)) ? SEL_IO_PORT :
    config_hit ? SEL_CONFIG :
    ~pins.attr_sel_n ? SEL_INFO_BYTE :
    SEL_MEM_PORT;
  wire [`ADDR_WIDTH-1:0] next_addr = disk_mode ? {8'h00, task_addr} : card_addr;
  wire do_read = rd_fall & disk_selected & pins.dma_ack_n;
  wire do_write = wr_fall & disk_selected & pins.dma_ack_n;
  wire cfg_write = do_write & ~disk_mode & config_hit;
  wire ready_change = (ready_in != ready_prev) | (write_protect_in != protect_prev);
  wire alert_enabled = io_mode & config_reg[`CFG_ALERT_ENABLE_BIT];
  wire next_pending = alert_enabled & (ready_change | (alert_pending & ~cfg_write));
  wire [`DATA_WIDTH-1:0] next_write_data = wide ? pins.data_wire : {8'h00, pins.data_wire[7:0]};
  wire diag_low = disk_mode & ~sync_diag[2] & ~sync_diag[1];

  // ***********************************************
  // Registered state
  // ***********************************************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
      card_reset_raw <= 1'b0;
      card_reset_out <= 1'b0;
    end else begin
      rd_prev <= rd_level;
      wr_prev <= wr_level;
      card_reset_raw <= reset_level;
      card_reset_out <= reset_active;
    end
  end

  // Config byte is reached only through the config space in card modes
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      config_reg <= `CFG_RESET_VALUE;
    end else if (cfg_write) begin
      config_reg <= pins.data_wire[7:0];
    end
  end

  // Status alert: a fresh change wins over a clearing config write
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ready_prev <= 1'b0;
      protect_prev <= 1'b0;
      alert_pending <= 1'b0;
      status_change_alert_n_out <= 1'b1;
    end else begin
      ready_prev <= ready_in;
      protect_prev <= write_protect_in;
      alert_pending <= next_pending;
      status_change_alert_n_out <= ~next_pending;
    end
  end

  // Access pulses last one cycle
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_read_out <= 1'b0;
      reg_write_out <= 1'b0;
    end else begin
      reg_read_out <= do_read;
      reg_write_out <= do_write;
    end
  end

  // Decoded target holds until the next taken access
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_select_out <= SEL_NONE;
      reg_addr_out <= '0;
      wide_access_out <= 1'b0;
      write_data_out <= '0;
    end else if (do_read | do_write) begin
      reg_select_out <= next_select;
      reg_addr_out <= next_addr;
      wide_access_out <= wide;
      write_data_out <= next_write_data;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      master_diag_seen_out <= 1'b0;
    end else begin
      master_diag_seen_out <= diag_low;
    end
  end

  // ***********************************************
  // Pin drivers
  // ***********************************************
  logic read_active;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      read_active <= 1'b0;
    end else begin
      read_active <= ~rd_level & selected & pins.dma_ack_n;
    end
  end
  assign pins.card_data = read_data_in;
  assign pins.card_data_low_oe = read_active;
  // Upper lanes stay released unless a word read or any disk mode read is made
  assign pins.card_data_high_oe = read_active & (wide | disk_mode);
  // Pin 45: battery detect two high in memory mode, audio in I/O mode
  assign pins.pin45_out = mem_mode ? 1'b1 :
                          (audio_supported_in ? ~audio_in : 1'b1);
  assign pins.pin45_oe = mem_mode | io_mode;
  // Pin 46: battery detect one, status alert or pass diagnostic
  assign pins.pin46_out = mem_mode ? 1'b1 :
                          io_mode ? status_change_alert_n_out :
                          ~diag_pass_in;
  assign pins.pin46_oe = mem_mode | io_mode | diag_pass_in;

endmodule

/* verilog/card_pins_params.svh */
// Constants shared by both ends of the card host pin interface
`ifndef CARD_PINS_PARAMS_SVH
`define CARD_PINS_PARAMS_SVH

// Address and data widths
`define ADDR_WIDTH 11
`define TASK_ADDR_WIDTH 3
`define DATA_WIDTH 16
`define BYTE_WIDTH 8

// Address space split in card modes (byte offsets within a space)
`define CONFIG_BASE 11'h200
`define IO_PORT_LIMIT 11'h010

// Status change enable bit position in the config and status register
`define CFG_ALERT_ENABLE_BIT 5
`define CFG_RESET_VALUE 8'h00

// Diagnostic handshake: wait in cycles, unused; host samples pass signal without waiting
`define DIAG_WAIT_CYCLES 16'h0010

// Host strobe length: last count value of the strobe phase
`define STROBE_LAST_COUNT 3'h5

`endif

/* verilog/card_pins_pkg.sv */
// Types shared by both ends of the card host pin interface
package card_pins_pkg;

  typedef enum logic [1:0] {
    MODE_MEMORY,
    MODE_IO,
    MODE_DISK
  } card_mode_type;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_IO_PORT,
    SEL_MEM_PORT,
    SEL_INFO_BYTE,
    SEL_CONFIG,
    SEL_TASK_FILE
  } reg_select_type;

endpackage

/* verilog/card_pins_if.sv */
// Pin-level carrier between the host controller and the card
`timescale 1ns/1ps
`include "card_pins_params.svh"
interface card_pins_if;
  import card_pins_pkg::*;
  logic [`ADDR_WIDTH-1:0] addr;
  logic attr_sel_n;
  logic reset_pin;
  logic chip_enable_one_n;
  logic chip_enable_two_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic [`DATA_WIDTH-1:0] host_data;
  logic host_data_low_oe;
  logic host_data_high_oe;
  logic [`DATA_WIDTH-1:0] card_data;
  logic card_data_low_oe;
  logic card_data_high_oe;
  logic drive_select_n;
  logic dma_ack_n;
  logic pin45_out;
  logic pin45_oe;
  logic pin46_out;
  logic pin46_oe;
  logic host_diag_out;
  logic host_diag_oe;
  logic [`DATA_WIDTH-1:0] data_wire;
  logic pin45_wire;
  logic pin46_wire;

  // Resolve shared wires; undriven pins float high through pull-ups
  assign data_wire[7:0] = card_data_low_oe ? card_data[7:0] :
                          host_data_low_oe ? host_data[7:0] : 8'hff;
  assign data_wire[15:8] = card_data_high_oe ? card_data[15:8] :
                           host_data_high_oe ? host_data[15:8] : 8'hff;
  assign pin45_wire = pin45_oe ? pin45_out : 1'b1;
  assign pin46_wire = (pin46_oe ? pin46_out : 1'b1) & (host_diag_oe ? host_diag_out : 1'b1);

  modport card (
    input addr, attr_sel_n, reset_pin, chip_enable_one_n, chip_enable_two_n,
    input read_strobe_n, write_strobe_n, data_wire, drive_select_n, dma_ack_n, pin46_wire,
    output card_data, card_data_low_oe, card_data_high_oe,
    output pin45_out, pin45_oe, pin46_out, pin46_oe
  );
  modport host (
    output addr, attr_sel_n, reset_pin, chip_enable_one_n, chip_enable_two_n,
    output read_strobe_n, write_strobe_n, host_data, host_data_low_oe, host_data_high_oe,
    output drive_select_n, dma_ack_n, host_diag_out, host_diag_oe,
    input data_wire, pin45_wire, pin46_wire
  );
endinterface

/* verilog/host_pin_end.sv */
// Host end: drives the card pins and performs strobed accesses
`timescale 1ns/1ps
`include "card_pins_params.svh"
module host_pin_end
  import card_pins_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  card_pins_if.host pins,
  input wire card_mode_type mode_in,
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic req_attr_in,
  input wire logic req_wide_in,
  input wire logic [`ADDR_WIDTH-1:0] req_addr_in,
  input wire logic [`DATA_WIDTH-1:0] req_data_in,
  input wire logic upper_address_in,
  input wire logic card_reset_req_in,
  input wire logic diag_drive_in,
  output logic busy_out,
  output logic done_out,
  output logic [`DATA_WIDTH-1:0] read_data_out,
  output logic status_change_alert_n_out,
  output logic pass_diagnostic_n_out
);

  typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} host_state_type;
  host_state_type state;
  logic [2:0] count;
  logic write_op;
  logic wide_op;
  logic [2:0] sync_alert;
  logic [2:0] sync_diag;

  wire disk_mode = (mode_in == MODE_DISK);
  // Higher address lines grounded in disk mode
  wire [`ADDR_WIDTH-1:0] drive_addr = disk_mode ? {8'h00, req_addr_in[2:0]} : req_addr_in;
  wire take = (state == IDLE) & req_in;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= IDLE;
      count <= 3'h0;
      write_op <= 1'b0;
      wide_op <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      read_data_out <= '0;
      pins.addr <= '0;
      pins.attr_sel_n <= 1'b1;
      pins.chip_enable_one_n <= 1'b1;
      pins.chip_enable_two_n <= 1'b1;
      pins.read_strobe_n <= 1'b1;
      pins.write_strobe_n <= 1'b1;
      pins.host_data <= '0;
      pins.host_data_low_oe <= 1'b0;
      pins.host_data_high_oe <= 1'b0;
      pins.reset_pin <= 1'b0;
      sync_alert <= 3'h7;
      sync_diag <= 3'h7;
      status_change_alert_n_out <= 1'b1;
      pass_diagnostic_n_out <= 1'b1;
    end else begin
      pins.reset_pin <= disk_mode ? ~card_reset_req_in : card_reset_req_in;
      sync_alert <= {sync_alert[1:0], pins.pin46_wire};
      sync_diag <= {sync_diag[1:0], pins.pin46_wire};
      if (sync_alert[2] == sync_alert[1]) begin
        status_change_alert_n_out <= sync_alert[1] | disk_mode;
      end
      if (sync_diag[2] == sync_diag[1]) begin
        pass_diagnostic_n_out <= sync_diag[1] | ~disk_mode;
      end
      done_out <= 1'b0;
      case (state)
        IDLE: begin
          if (take) begin
            state <= SETUP;
            busy_out <= 1'b1;
            write_op <= req_write_in;
            wide_op <= req_wide_in & ~disk_mode;
            pins.addr <= drive_addr;
            pins.attr_sel_n <= ~req_attr_in;
            pins.chip_enable_one_n <= 1'b0;
            pins.chip_enable_two_n <= ~(req_wide_in & ~disk_mode);
            pins.host_data <= req_data_in;
            pins.host_data_low_oe <= req_write_in;
            pins.host_data_high_oe <= req_write_in & req_wide_in & ~disk_mode;
          end
        end
        SETUP: begin
          state <= STROBE;
          count <= 3'h0;
          pins.read_strobe_n <= write_op;
          pins.write_strobe_n <= ~write_op;
        end
        STROBE: begin
          count <= count + 3'h1;
          if (count == `STROBE_LAST_COUNT) begin
            state <= HOLD;
            read_data_out <= wide_op ? pins.data_wire : {8'h00, pins.data_wire[7:0]};
            pins.read_strobe_n <= 1'b1;
            pins.write_strobe_n <= 1'b1;
          end
        end
        HOLD: begin
          state <= IDLE;
          busy_out <= 1'b0;
          done_out <= 1'b1;
          pins.chip_enable_one_n <= 1'b1;
          pins.chip_enable_two_n <= 1'b1;
          pins.host_data_low_oe <= 1'b0;
          pins.host_data_high_oe <= 1'b0;
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Drive select never floats: upper address bit in card modes
  assign pins.drive_select_n = disk_mode ? 1'b0 : upper_address_in;
  // No DMA used: acknowledge held high
  assign pins.dma_ack_n = 1'b1;
  assign pins.host_diag_out = 1'b0;
  assign pins.host_diag_oe = disk_mode & diag_drive_in;

endmodule

/* verif/card_host_pin_interface_checker.sv */
// Concurrent checks on the pins between the host end and the card end, and on the card access outputs
`timescale 1ns/1ps
`include "card_pins_params.svh"
module card_host_pin_interface_checker
  import card_pins_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire card_mode_type mode_in,
  input wire logic audio_supported_in,
  input wire logic diag_pass_in,
  input wire logic [`ADDR_WIDTH-1:0] addr,
  input wire logic chip_enable_one_n,
  input wire logic write_strobe_n,
  input wire logic dma_ack_n,
  input wire logic pin45_out,
  input wire logic pin45_oe,
  input wire logic pin46_out,
  input wire logic pin46_oe,
  input wire logic pin45_wire,
  input wire logic pin46_wire,
  input wire logic reg_write_out,
  input wire logic reg_read_out,
  input wire logic [`ADDR_WIDTH-1:0] reg_addr_out
);
  // ********************
  // Pin and card access output checks
  // ********************
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  AST_BATTERY_ONE: assert property ((mode_in == MODE_MEMORY) |-> (pin46_oe && pin46_out))
    else $error("battery one not high");
  AST_BATTERY_TWO: assert property ((mode_in == MODE_MEMORY) |-> (pin45_oe && pin45_out))
    else $error("battery two not high");
  AST_AUDIO_NEGATED: assert property ((mode_in == MODE_IO && !audio_supported_in) [*3] |-> pin45_wire)
    else $error("audio not negated");
  AST_DIAG_OPEN_DRAIN: assert property ((mode_in == MODE_DISK && pin46_oe) |-> !pin46_out)
    else $error("diag pin driven high");
  AST_DIAG_PASS: assert property ((mode_in == MODE_DISK && diag_pass_in) [*3] |-> !pin46_wire)
    else $error("pass not shown");
  AST_TASK_ADDR: assert property ((mode_in == MODE_DISK && (reg_write_out || reg_read_out)) |->
    reg_addr_out[10:3] == 8'h00)
    else $error("task address too wide");
  AST_HOST_GROUNDS: assert property ((mode_in == MODE_DISK && !chip_enable_one_n) |-> addr[10:3] == 8'h00)
    else $error("upper address not grounded");
  AST_DMA_HIGH: assert property (dma_ack_n)
    else $error("dma ack not high");
  AST_WRITE_TAKEN: assert property (($fell(write_strobe_n) && !chip_enable_one_n && dma_ack_n) |->
    ##[3:5] reg_write_out)
    else $error("write not taken");
  AST_PULSE_SINGLE: assert property ((reg_write_out || reg_read_out) |=> !(reg_write_out || reg_read_out))
    else $error("access pulse too long");
endmodule

/* verif/card_host_pin_interface_test.sv */
// Bench joining host and card ends, plus a hand-driven second card
`timescale 1ns/1ps
`include "card_pins_params.svh"
module card_host_pin_interface_test;
  import card_pins_pkg::*;
  typedef struct {card_mode_type mode; logic wr; logic attr; logic wide; logic [10:0] addr; logic [15:0] data;
    reg_select_type sel;} row_type;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  card_mode_type mode = MODE_MEMORY;
  logic ready = 1'b0, protect = 1'b0, audio = 1'b0, audio_ok = 1'b0, diag_pass = 1'b0, diag_drive = 1'b0;
  logic req = 1'b0, req_wr = 1'b0, req_attr = 1'b0, req_wide = 1'b0, upper = 1'b1, card_rst = 1'b0;
  logic [10:0] req_addr = 11'h000;
  logic [15:0] req_data = 16'h0000;
  logic [15:0] rd_data = 16'hbeef;
  logic [2:0] sel;
  logic [10:0] reg_addr, reg_addr2;
  logic rd_pulse, wr_pulse, wide, c_reset, diag_seen, alert_card, busy, done, alert_host, pass_host, rd2, wr2;
  logic [15:0] wr_data, host_rd;
  int pulses = 0, pulses2 = 0, bad_count = 0, n_checks = 0;
  row_type rows [7] = '{
    '{MODE_MEMORY, 1'b1, 1'b0, 1'b1, 11'h123, 16'ha5c3, SEL_MEM_PORT},
    '{MODE_MEMORY, 1'b0, 1'b1, 1'b0, 11'h1ff, 16'h0000, SEL_INFO_BYTE},
    '{MODE_MEMORY, 1'b1, 1'b1, 1'b0, 11'h200, 16'h0000, SEL_CONFIG},
    '{MODE_IO, 1'b1, 1'b1, 1'b1, 11'h00f, 16'h5a3c, SEL_IO_PORT},
    '{MODE_IO, 1'b0, 1'b1, 1'b1, 11'h005, 16'h0000, SEL_IO_PORT},
    '{MODE_DISK, 1'b1, 1'b0, 1'b0, 11'h7fd, 16'h9977, SEL_TASK_FILE},
    '{MODE_DISK, 1'b0, 1'b0, 1'b0, 11'h006, 16'h0000, SEL_TASK_FILE}};
  card_pins_if pins ();
  card_pins_if pins2 ();
  card_pin_end u_card_pin_end (.clk_in(clk_in), .reset_in(reset_in), .pins(pins.card), .mode_in(mode),
    .ready_in(ready), .write_protect_in(protect), .audio_in(audio), .audio_supported_in(audio_ok),
    .diag_pass_in(diag_pass), .read_data_in(rd_data), .reg_select_out(sel), .reg_addr_out(reg_addr),
    .reg_read_out(rd_pulse), .reg_write_out(wr_pulse), .wide_access_out(wide), .write_data_out(wr_data),
    .card_reset_out(c_reset), .master_diag_seen_out(diag_seen), .status_change_alert_n_out(alert_card));
  host_pin_end u_host_pin_end (.clk_in(clk_in), .reset_in(reset_in), .pins(pins.host), .mode_in(mode),
    .req_in(req), .req_write_in(req_wr), .req_attr_in(req_attr), .req_wide_in(req_wide), .req_addr_in(req_addr),
    .req_data_in(req_data), .upper_address_in(upper), .card_reset_req_in(card_rst), .diag_drive_in(diag_drive),
    .busy_out(busy), .done_out(done), .read_data_out(host_rd), .status_change_alert_n_out(alert_host),
    .pass_diagnostic_n_out(pass_host));
  card_pin_end u_card_pin_end_b (.clk_in(clk_in), .reset_in(reset_in), .pins(pins2.card), .mode_in(mode),
    .ready_in(ready), .write_protect_in(protect), .audio_in(audio), .audio_supported_in(audio_ok),
    .diag_pass_in(diag_pass), .read_data_in(rd_data), .reg_select_out(), .reg_addr_out(reg_addr2),
    .reg_read_out(rd2), .reg_write_out(wr2), .wide_access_out(), .write_data_out(),
    .card_reset_out(), .master_diag_seen_out(), .status_change_alert_n_out());
  card_host_pin_interface_checker u_checker (.clk_in(clk_in), .reset_in(reset_in), .mode_in(mode),
    .audio_supported_in(audio_ok), .diag_pass_in(diag_pass), .addr(pins.addr),
    .chip_enable_one_n(pins.chip_enable_one_n), .write_strobe_n(pins.write_strobe_n), .dma_ack_n(pins.dma_ack_n),
    .pin45_out(pins.pin45_out), .pin45_oe(pins.pin45_oe), .pin46_out(pins.pin46_out), .pin46_oe(pins.pin46_oe),
    .pin45_wire(pins.pin45_wire), .pin46_wire(pins.pin46_wire), .reg_write_out(wr_pulse),
    .reg_read_out(rd_pulse), .reg_addr_out(reg_addr));
  // ********************
  // Shared tasks
  // ********************
  task automatic check_bit(input string what, input logic exp, input logic seen);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic check_vec(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic do_reset(input card_mode_type m);
    @(negedge clk_in);
    reset_in = 1'b1;
    mode = m;
    repeat (12) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (5) @(negedge clk_in);
  endtask
  task automatic access(input row_type r);
    int i;
    @(negedge clk_in);
    {req, req_wr, req_attr, req_wide, req_addr, req_data} = {1'b1, r.wr, r.attr, r.wide, r.addr, r.data};
    @(negedge clk_in);
    req = 1'b0;
    check_bit("busy", 1'b1, busy);
    i = 0;
    while (done !== 1'b1 && i < 30) begin
      @(negedge clk_in);
      i++;
    end
    check_bit("done", 1'b1, done);
    check_bit("busy idle", 1'b0, busy);
  endtask
  // Second card: the bench plays a host that breaks the pin duties
  task automatic strobe_b(input logic ack_n);
    @(negedge clk_in);
    {pins2.dma_ack_n, pins2.addr, pins2.chip_enable_one_n, pins2.write_strobe_n} = {ack_n, 11'h7fa, 2'b00};
    repeat (6) @(negedge clk_in);
    {pins2.chip_enable_one_n, pins2.write_strobe_n} = 2'b11;
    repeat (4) @(negedge clk_in);
  endtask
  always @(posedge clk_in) begin
    pulses = pulses + ((rd_pulse === 1'b1 || wr_pulse === 1'b1) ? 1 : 0);
    pulses2 = pulses2 + ((rd2 === 1'b1 || wr2 === 1'b1) ? 1 : 0);
  end
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    repeat (4000) @(posedge clk_in);
    bad_count++;
    close_out();
  end
  // ********************
  // Scenarios
  // ********************
  initial begin
    int p0;
    logic [10:0] ea;
    logic [15:0] ed;
    {pins2.chip_enable_one_n, pins2.chip_enable_two_n, pins2.read_strobe_n, pins2.write_strobe_n} = 4'hf;
    {pins2.dma_ack_n, pins2.reset_pin, pins2.attr_sel_n, pins2.drive_select_n, pins2.host_diag_out} = 5'h1f;
    {pins2.host_data_low_oe, pins2.host_data_high_oe, pins2.host_diag_oe, pins2.addr} = 14'h0000;
    pins2.host_data = 16'h0000;
    do_reset(MODE_MEMORY);
    check_bit("alert idle", 1'b1, alert_card);
    check_bit("battery one", 1'b1, pins.pin46_wire);
    check_bit("battery two", 1'b1, pins.pin45_wire);
    check_bit("drive select", 1'b1, pins.drive_select_n);
    foreach (rows[k]) begin
      if (rows[k].mode !== mode)
        do_reset(rows[k].mode);
      p0 = pulses;
      access(rows[k]);
      ea = (rows[k].mode == MODE_DISK) ? {8'h00, rows[k].addr[2:0]} : rows[k].addr;
      ed = rows[k].wr ? rows[k].data : rd_data;
      ed = rows[k].wide ? ed : {8'h00, ed[7:0]};
      check_vec("pulses", 16'(p0 + 1), 16'(pulses));
      check_vec("select", {13'h0000, 3'(rows[k].sel)}, {13'h0000, sel});
      check_vec("address", {5'h00, ea}, {5'h00, reg_addr});
      check_bit("wide", rows[k].wide, wide);
      check_vec("data", ed, rows[k].wr ? wr_data : host_rd);
    end
    card_rst = 1'b1;
    repeat (6) @(negedge clk_in);
    check_bit("card reset", 1'b1, c_reset);
    check_bit("reset pin low", 1'b0, pins.reset_pin);
    card_rst = 1'b0;
    diag_pass = 1'b1;
    repeat (6) @(negedge clk_in);
    check_bit("pass seen", 1'b0, pass_host);
    diag_pass = 1'b0;
    repeat (6) @(negedge clk_in);
    check_bit("diag idle", 1'b0, diag_seen);
    check_bit("pass idle", 1'b1, pass_host);
    diag_drive = 1'b1;
    repeat (6) @(negedge clk_in);
    check_bit("master diag", 1'b1, diag_seen);
    diag_drive = 1'b0;
    p0 = pulses2;
    strobe_b(1'b0);
    check_vec("refused", 16'(p0), 16'(pulses2));
    strobe_b(1'b1);
    check_vec("taken", 16'(p0 + 1), 16'(pulses2));
    check_vec("task addr", 16'h0002, {5'h00, reg_addr2});
    do_reset(MODE_IO);
    audio = 1'b1;
    repeat (4) @(negedge clk_in);
    check_bit("audio off", 1'b1, pins.pin45_wire);
    audio_ok = 1'b1;
    repeat (4) @(negedge clk_in);
    check_bit("audio on", 1'b0, pins.pin45_wire);
    card_rst = 1'b1;
    repeat (6) @(negedge clk_in);
    check_bit("card reset io", 1'b1, c_reset);
    check_bit("reset pin high", 1'b1, pins.reset_pin);
    card_rst = 1'b0;
    repeat (6) @(negedge clk_in);
    check_bit("card reset off", 1'b0, c_reset);
    ready = 1'b1;
    repeat (3) @(negedge clk_in);
    check_bit("alert masked", 1'b1, alert_card);
    access('{MODE_IO, 1'b1, 1'b1, 1'b0, 11'h200, 16'h0020, SEL_CONFIG});
    protect = 1'b1;
    repeat (3) @(negedge clk_in);
    check_bit("alert card", 1'b0, alert_card);
    repeat (5) @(negedge clk_in);
    check_bit("alert host", 1'b0, alert_host);
    access('{MODE_IO, 1'b1, 1'b1, 1'b0, 11'h200, 16'h0000, SEL_CONFIG});
    repeat (3) @(negedge clk_in);
    check_bit("alert cleared", 1'b1, alert_card);
    close_out();
  end
endmodule
